// *** design/crc_checksum_engine.sv ***
// checksum engine with wishbone slave, input fifo and its fifo module
`timescale 1ns/10ps

// -----------------------------------------------------------------------
// word fifo: parameterised width and depth, valid/ready on both sides
// -----------------------------------------------------------------------
module crc_word_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // storage, no reset needed
  logic [AW:0] wr_ptr;  // extra bit tells full from empty
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic push;
  logic pop;

  // honest flags from the pointer pair
  always_comb begin
    out_valid = (wr_ptr != rd_ptr);
    in_ready = !((wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) &&
                 (wr_ptr[AW] != rd_ptr[AW]));
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    out_data = mem[rd_ptr[AW-1:0]];
  end

  // pointers and storage
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule

// What this block does
// - three polynomials: ccitt, crc16, ethernet crc32
// - input-reverse mirrors each byte before folding
// - input-complement inverts each byte before folding
// - output-reverse mirrors result on read
// - output-complement inverts result on read
// - full-word seed write (all four byte selects) loads sum, starts new computation
// - bytes folded most significant byte first
// - result read gives full 32-bit checksum in crc32 mode
// - 16-bit polynomials give a 16-bit result
// - config and running sum read back, resumable
// - module reset restores config and sum
module crc_checksum_engine #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o
);
  // ---------------------------------------------------------------------
  // state and wiring
  // ---------------------------------------------------------------------
  logic [crc_pkg::CFG_W-1:0] cfg;  // mode register
  logic [crc_pkg::CFG_W-1:0] next_cfg;
  logic [31:0] sum;  // running checksum, raw
  logic [31:0] next_sum;
  logic [31:0] next_dat_o;
  logic next_ack;
  logic req;  // a bus request waits for its answer
  logic commit;  // the ack edge: writes take effect here
  logic hit_mode, hit_seed, hit_sum, hit_data, hit_ctrl;
  logic can_answer;  // no stall needed for this access
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [35:0] fifo_out_data;
  logic wr_data, wr_seed, wr_mode, wr_soft;

  // ---------------------------------------------------------------------
  // checksum helpers
  // ---------------------------------------------------------------------
  // one byte, msb first, non-reflected shift register form
  function automatic logic [31:0] fold_byte(input logic [31:0] c,
                                            input logic [7:0] d,
                                            input logic [1:0] m);
    logic fb;
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (m == crc_pkg::POLY_32) begin
        fb = r[31] ^ d[i];
        r = {r[30:0], 1'b0};
        if (fb) begin
          r = r ^ crc_pkg::GEN_32;
        end
      end else begin
        fb = r[15] ^ d[i];
        r = {16'h0000, r[14:0], 1'b0};
        if (fb) begin
          r[15:0] = r[15:0] ^ ((m == crc_pkg::POLY_16) ?
                    crc_pkg::GEN_16 : crc_pkg::GEN_CCITT);
        end
      end
    end
    return r;
  endfunction

  // input byte conditioning
  function automatic logic [7:0] prep_byte(input logic [7:0] d,
                                           input logic [5:0] c);
    logic [7:0] r;
    r = d;
    if (c[crc_pkg::REV_IN_BIT]) begin
      r = {<<{d}};
    end
    if (c[crc_pkg::CPL_IN_BIT]) begin
      r = ~r;
    end
    return r;
  endfunction

  // a fifo entry: four lanes, lane 3 first, only enabled lanes fold
  function automatic logic [31:0] fold_word(input logic [31:0] c,
                                            input logic [35:0] e,
                                            input logic [5:0] g);
    logic [31:0] r;
    r = c;
    for (int b = 3; b >= 0; b--) begin
      if (e[32+b]) begin
        r = fold_byte(r, prep_byte(e[8*b +: 8], g),
                      g[crc_pkg::POLY_LSB +: 2]);
      end
    end
    return r;
  endfunction

  // result as software sees it
  function automatic logic [31:0] shape_out(input logic [31:0] c,
                                            input logic [5:0] g);
    logic [31:0] r;
    r = c;
    if (g[crc_pkg::POLY_LSB +: 2] == crc_pkg::POLY_32) begin
      if (g[crc_pkg::REV_OUT_BIT]) begin
        r = {<<{c}};
      end
      if (g[crc_pkg::CPL_OUT_BIT]) begin
        r = ~r;
      end
    end else begin  // 16-bit result, upper half zero
      r = {16'h0000, c[15:0]};
      if (g[crc_pkg::REV_OUT_BIT]) begin
        r[15:0] = {<<{c[15:0]}};
      end
      if (g[crc_pkg::CPL_OUT_BIT]) begin
        r[15:0] = ~r[15:0];
      end
    end
    return r;
  endfunction

  // ---------------------------------------------------------------------
  // wishbone slave
  // ---------------------------------------------------------------------
  // data writes only stall when the fifo is full; every other access
  // waits for the fifo to drain so that config and sum are consistent
  always_comb begin
    req = cyc_i && stb_i;
    commit = req && ack_o;
    hit_mode = (adr_i == crc_pkg::OFS_MODE);
    hit_seed = (adr_i == crc_pkg::OFS_SEED);
    hit_sum = (adr_i == crc_pkg::OFS_SUM);
    hit_data = (adr_i == crc_pkg::OFS_DATA);
    hit_ctrl = (adr_i == crc_pkg::OFS_CTRL);
    can_answer = (hit_data && we_i) ? fifo_in_ready
                                    : !fifo_out_valid;
    next_ack = req && !ack_o && can_answer;
    wr_data = commit && we_i && hit_data;
    wr_seed = commit && we_i && hit_seed && (&sel_i);
    wr_mode = commit && we_i && hit_mode && sel_i[0];
    wr_soft = commit && we_i && hit_ctrl && sel_i[0] &&
              dat_i[crc_pkg::SOFT_RST_BIT];
    // read data is captured with the ack; unmapped reads give zero
    // a stalled read leaves dat_o at zero, so data only shows with ack
    next_dat_o = 32'h00000000;
    if (req && !ack_o && !we_i && can_answer) begin
      if (hit_mode) begin
        next_dat_o = {26'h0000000, cfg};
      end else if (hit_seed) begin
        next_dat_o = sum;
      end else if (hit_sum) begin
        next_dat_o = shape_out(sum, cfg);
      end
    end
  end

  // bus answer registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_o <= 1'b0;
      dat_o <= 32'h00000000;
    end else begin
      ack_o <= next_ack;
      dat_o <= next_dat_o;
    end
  end

  // ---------------------------------------------------------------------
  // data path fifo
  // ---------------------------------------------------------------------
  // the engine pauses draining while a config access commits, which can
  // only happen with the fifo empty, so no byte is ever dropped
  assign fifo_out_ready = !(wr_seed || wr_mode || wr_soft);

  crc_word_fifo #(
    .WIDTH(36),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(wr_data),
    .in_ready(fifo_in_ready),
    .in_data({sel_i, dat_i}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ---------------------------------------------------------------------
  // configuration and running checksum
  // ---------------------------------------------------------------------
  always_comb begin
    next_cfg = cfg;
    next_sum = sum;
    if (wr_soft) begin
      next_cfg = crc_pkg::CFG_RST;
      next_sum = crc_pkg::SUM_RST;
    end else if (wr_mode) begin
      next_cfg = dat_i[crc_pkg::CFG_W-1:0];
    end else if (wr_seed) begin  // full seed, 16-bit modes use low half
      next_sum = dat_i;
    end else if (fifo_out_valid && fifo_out_ready) begin
      next_sum = fold_word(sum, fifo_out_data, cfg);
    end
  end

  // config and sum registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfg <= crc_pkg::CFG_RST;
      sum <= crc_pkg::SUM_RST;
    end else begin
      cfg <= next_cfg;
      sum <= next_sum;
    end
  end

  // ---------------------------------------------------------------------
  // assertions and covers
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  ack_cause_a: assert property (ack_o |-> $past(req))
    else $error("ack without a request");
  drain_bound_a: assert property (
    wr_data |-> ##[1:9] !fifo_out_valid)
    else $error("data write not absorbed in time");
  seed_load_a: assert property (
    wr_seed |=> sum == $past(dat_i))
    else $error("seed not loaded into running sum");
  soft_reset_a: assert property (
    wr_soft |=> (sum == crc_pkg::SUM_RST) &&
               (cfg == crc_pkg::CFG_RST))
    else $error("module reset did not restore state");
  upper_zero_a: assert property (
    (cfg[1:0] != crc_pkg::POLY_32) && fifo_out_valid &&
    !sum[31] && !sum[16] |=> sum[31:16] == 16'h0000)
    else $error("16-bit polynomial touched upper half");
  result_shape_a: assert property (
    ack_o && $past(req && !we_i && hit_sum) |->
    dat_o == shape_out($past(sum), $past(cfg)))
    else $error("result read mismatch");
  short_result_a: assert property (
    ack_o && $past(req && !we_i && hit_sum &&
    (cfg[1:0] != crc_pkg::POLY_32)) |->
    dat_o[31:16] == 16'h0000)
    else $error("16-bit result has upper bits set");
  mode_back_a: assert property (
    ack_o && $past(req && !we_i && hit_mode) |->
    dat_o[crc_pkg::CFG_W-1:0] == cfg)
    else $error("mode read back differs");
  cfg_order_a: assert property (
    fifo_out_valid |=> $stable(cfg))
    else $error("mode changed with data pending");
  cpl_out_a: assert property (
    ack_o && $past(req && !we_i && hit_sum &&
    (cfg[1:0] == crc_pkg::POLY_32) && cfg[crc_pkg::CPL_OUT_BIT] &&
    !cfg[crc_pkg::REV_OUT_BIT]) |-> dat_o == ~$past(sum))
    else $error("output complement missing");

  // dat_o idles at zero, so a late sample never sees stale data
  data_idle_a: assert property (!ack_o |-> dat_o == 32'h00000000)
    else $error("read data shown without ack");
  // a word pushed into an empty fifo is folded on the very next edge
  absorb_one_a: assert property (
    wr_data && !fifo_out_valid |=>
    fifo_out_valid ##1 !fifo_out_valid)
    else $error("data word not folded in one cycle");

  // main scenarios that should be seen at least once
  seed_write_c: cover property (wr_seed);
  data_burst_c: cover property (wr_data ##3 wr_data);
  mode_switch_c: cover property (wr_mode ##[1:8] wr_data);
  result_read_c: cover property (ack_o && !we_i && hit_sum);
  fifo_full_c: cover property (!fifo_in_ready);
endmodule

// *** design/crc_pkg.sv ***
// constants shared by the checksum engine: register map, fields, resets
package crc_pkg;

  // ---------------------------------------------------------------------
  // register byte offsets on the wishbone slave
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;  // configuration, read/write
  localparam logic [7:0] OFS_SEED = 8'h04;  // seed write, running sum read
  localparam logic [7:0] OFS_SUM = 8'h08;   // final checksum, read only
  localparam logic [7:0] OFS_DATA = 8'h0c;  // message bytes, write only
  localparam logic [7:0] OFS_CTRL = 8'h10;  // module reset, write only

  // ---------------------------------------------------------------------
  // field positions in the mode register
  // ---------------------------------------------------------------------
  localparam int POLY_LSB = 0;      // two-bit polynomial select
  localparam int REV_IN_BIT = 2;    // mirror each input byte
  localparam int CPL_IN_BIT = 3;    // invert each input byte
  localparam int REV_OUT_BIT = 4;   // mirror the result
  localparam int CPL_OUT_BIT = 5;   // invert the result
  localparam int CFG_W = 6;         // implemented mode bits
  localparam int SOFT_RST_BIT = 0;  // control register: module reset

  // ---------------------------------------------------------------------
  // polynomial selections and generator values
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    POLY_CCITT = 2'h0,  // x16+x12+x5+1
    POLY_16 = 2'h1,     // x16+x15+x2+1
    POLY_32 = 2'h2      // ethernet 32-bit
  } poly_sel_t;

  localparam logic [15:0] GEN_CCITT = 16'h1021;
  localparam logic [15:0] GEN_16 = 16'h8005;
  localparam logic [31:0] GEN_32 = 32'h04c11db7;

  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RST = 6'h00;
  localparam logic [31:0] SUM_RST = 32'h0000ffff;

endpackage

// *** tb/tb.sv ***
// self-checking bench for the checksum engine over classic wishbone
`timescale 1ns/10ps
module tb;
  // ---------------------------------------------------------------------
  // stimulus, expectations and counters
  // ---------------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n = 1'b0;  // held low for the first 20 cycles
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  logic we_i = 1'b0;
  logic [7:0] adr_i = 8'h00;
  logic [31:0] dat_i = 32'h00000000;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_o;
  logic ack_o;
  int err_count = 0;
  int total_checks = 0;
  logic [31:0] ref_sum = 32'h0000ffff;  // expected running sum
  logic [5:0] ref_mode = 6'h00;  // expected configuration
  logic [31:0] rd;  // data taken at the ack edge
  logic [31:0] keep;  // running sum saved for a resume
  int lat;  // edges waited for the last answer, 1 means no wait state
  typedef struct {
    logic [5:0] mode;
    logic [31:0] seed;
    logic [31:0] exp;  // zero: reference model only
  } row_t;
  row_t rows [7];

  // free-running 250 MHz clock
  always #2 clk = ~clk;

  crc_checksum_engine #(.FIFO_DEPTH(8)) dut (.clk(clk), .reset_n(reset_n),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o));

  // ---------------------------------------------------------------------
  // reference model: msb-first, non-reflected shift
  // ---------------------------------------------------------------------
  function automatic logic [31:0] fold(logic [31:0] s, logic [7:0] b,
                                       logic [5:0] m);
    logic [7:0] x;
    logic [15:0] g;
    for (int i = 0; i < 8; i++) x[i] = m[2] ? b[7-i] : b[i];
    if (m[3]) x = ~x;
    g = (m[1:0] == crc_pkg::POLY_16) ? crc_pkg::GEN_16 : crc_pkg::GEN_CCITT;
    if (m[1:0] == crc_pkg::POLY_32) begin
      s = s ^ {x, 24'h000000};
      for (int i = 0; i < 8; i++)
        s = s[31] ? ((s << 1) ^ crc_pkg::GEN_32) : (s << 1);
    end else begin
      s[15:0] = s[15:0] ^ {x, 8'h00};
      s[31:16] = 16'h0000;  // 16-bit folds leave the upper half clear
      for (int i = 0; i < 8; i++)
        s[15:0] = s[15] ? ({s[14:0], 1'b0} ^ g) : {s[14:0], 1'b0};
    end
    return s;
  endfunction

  // result as read: mirror then invert over the polynomial width
  function automatic logic [31:0] shape(logic [31:0] s, logic [5:0] m);
    logic [31:0] r;
    logic [15:0] h;
    for (int i = 0; i < 32; i++) r[i] = m[4] ? s[31-i] : s[i];
    for (int i = 0; i < 16; i++) h[i] = m[4] ? s[15-i] : s[i];
    if (m[5]) r = ~r;
    if (m[5]) h = ~h;
    return (m[1:0] == crc_pkg::POLY_32) ? r : {16'h0000, h};
  endfunction

  // ---------------------------------------------------------------------
  // closing report, compare and bus tasks
  // ---------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      $display("BAD %0t got %h want %h", $time, g, e);
      err_count++;
    end
  endtask

  // one classic cycle; the model follows a write only once it is acked
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int n;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    for (n = 0; n < 40; n++) begin
      @(posedge clk);
      if (ack_o === 1'b1) break;
    end
    if (n == 40) begin
      $display("BAD %0t bus answer missing", $time);
      err_count++;
      tally_and_finish();
    end
    rd = dat_o;
    lat = n;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (w && a == crc_pkg::OFS_DATA)
      for (int i = 3; i >= 0; i--)
        if (s[i]) ref_sum = fold(ref_sum, d[i*8 +: 8], ref_mode);
    if (w && a == crc_pkg::OFS_SEED && s == 4'hf) ref_sum = d;
    if (w && a == crc_pkg::OFS_MODE) ref_mode = d[5:0];
    if (w && a == crc_pkg::OFS_CTRL && d[0]) begin
      ref_mode = crc_pkg::CFG_RST;
      ref_sum = crc_pkg::SUM_RST;
    end
    @(posedge clk);
  endtask

  // nine ascii digits; the last word carries one byte in lane 3 only
  task automatic feed_digits();
    wb(1'b1, crc_pkg::OFS_DATA, 32'h31323334, 4'hf);
    wb(1'b1, crc_pkg::OFS_DATA, 32'h35363738, 4'hf);
    wb(1'b1, crc_pkg::OFS_DATA, 32'h39aaaaaa, 4'h8);
  endtask

  // ---------------------------------------------------------------------
  // main sequence: reset state, table of modes, awkward cases
  // ---------------------------------------------------------------------
  initial begin
    rows[0] = '{6'h00, 32'h0000ffff, 32'h000029b1};
    rows[1] = '{6'h01, 32'h00000000, 32'h0000fee8};
    rows[2] = '{6'h02, 32'hffffffff, 32'h0376e6e7};
    rows[3] = '{6'h3c, 32'h0000ffff, 32'h00000000};
    rows[4] = '{6'h15, 32'h00000000, 32'h00000000};
    rows[5] = '{6'h2e, 32'hffffffff, 32'h00000000};
    rows[6] = '{6'h03, 32'h0000ffff, 32'h000029b1};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wb(1'b0, crc_pkg::OFS_MODE, 32'h0, 4'hf);
    chk(rd, 32'h00000000);
    wb(1'b0, crc_pkg::OFS_SEED, 32'h0, 4'hf);
    chk(rd, crc_pkg::SUM_RST);
    wb(1'b0, 8'h20, 32'h0, 4'hf);
    chk(rd, 32'h00000000);
    foreach (rows[r]) begin
      wb(1'b1, crc_pkg::OFS_MODE, {26'h0, rows[r].mode}, 4'h1);
      wb(1'b1, crc_pkg::OFS_SEED, rows[r].seed, 4'hf);
      feed_digits();
      wb(1'b0, crc_pkg::OFS_MODE, 32'h0, 4'hf);
      chk(rd, {26'h0, rows[r].mode});
      wb(1'b0, crc_pkg::OFS_SUM, 32'h0, 4'hf);
      chk(rd, shape(ref_sum, ref_mode));
      if (rows[r].exp != 32'h0) chk(rd, rows[r].exp);
    end
    // option change in mid-stream touches only later bytes
    wb(1'b1, crc_pkg::OFS_MODE, 32'h0, 4'h1);
    wb(1'b1, crc_pkg::OFS_SEED, 32'h0000ffff, 4'hf);
    wb(1'b1, crc_pkg::OFS_DATA, 32'h31323334, 4'hf);
    wb(1'b1, crc_pkg::OFS_MODE, 32'h0000000c, 4'h1);
    wb(1'b1, crc_pkg::OFS_DATA, 32'h35363738, 4'h6);
    wb(1'b0, crc_pkg::OFS_SUM, 32'h0, 4'hf);
    chk(rd, shape(ref_sum, ref_mode));
    // save, module reset, then resume from the saved state
    wb(1'b0, crc_pkg::OFS_SEED, 32'h0, 4'hf);
    keep = rd;
    chk(rd, ref_sum);
    wb(1'b1, crc_pkg::OFS_CTRL, 32'h00000001, 4'h1);
    wb(1'b0, crc_pkg::OFS_MODE, 32'h0, 4'hf);
    chk(rd, 32'h00000000);
    wb(1'b0, crc_pkg::OFS_SEED, 32'h0, 4'hf);
    chk(rd, crc_pkg::SUM_RST);
    wb(1'b1, crc_pkg::OFS_MODE, 32'h0000000c, 4'h1);
    wb(1'b1, crc_pkg::OFS_SEED, keep, 4'hf);
    wb(1'b1, crc_pkg::OFS_DATA, 32'h39aaaaaa, 4'h8);
    wb(1'b0, crc_pkg::OFS_SUM, 32'h0, 4'hf);
    chk(rd, shape(ref_sum, ref_mode));
    // back-to-back words, then an immediate read; a write to sum is ignored
    wb(1'b1, crc_pkg::OFS_MODE, 32'h00000036, 4'h1);
    wb(1'b1, crc_pkg::OFS_SEED, 32'hffffffff, 4'hf);
    for (int i = 1; i <= 12; i++)
      wb(1'b1, crc_pkg::OFS_DATA, i * 32'h01030507, 4'hf);
    chk(lat, 32'h00000001);
    wb(1'b1, crc_pkg::OFS_SUM, 32'h12345678, 4'hf);
    wb(1'b0, crc_pkg::OFS_SUM, 32'h0, 4'hf);
    chk(rd, shape(ref_sum, ref_mode));
    chk(lat, 32'h00000001);
    tally_and_finish();
  end
endmodule
